/* include/mfss_pkg.sv */
package mfss_pkg;
	localparam int CLK_NS = 25;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_TXS = 8'h04;
	localparam logic [7:0] ADR_RXS = 8'h08;
	localparam logic [7:0] ADR_FILL = 8'h0c;
	// ----------------------------------------------------------------
	// Transmit figures
	// ----------------------------------------------------------------
	localparam int TX_FIFO_BYTES = 80;
	localparam logic [6:0] TX_KEEP_BYTES = 7'h40;
	localparam logic [6:0] LATE_WIN_BYTES = 7'h40;
	localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
	localparam int HB_BITS = 40;
	localparam int BIT_NS_10 = 100;
	localparam int HB_CYC = HB_BITS * BIT_NS_10 / CLK_NS;
	localparam int XDEF_NS_10 = 2428800;
	localparam int XDEF_NS_100 = 242880;
	localparam int XDEF_CYC_10 = (XDEF_NS_10 + CLK_NS - 1) / CLK_NS;
	localparam int XDEF_CYC_100 = (XDEF_NS_100 + CLK_NS - 1) / CLK_NS;
	// ----------------------------------------------------------------
	// Receive figures
	// ----------------------------------------------------------------
	localparam int BLOCK_BYTES = 64;
	localparam logic [15:0] POS_LT_HI = 16'h000c;
	localparam logic [15:0] POS_LT_LO = 16'h000d;
	localparam logic [15:0] POS_VLT_HI = 16'h0010;
	localparam logic [15:0] POS_VLT_LO = 16'h0011;
	localparam logic [15:0] HDR_BYTES = 16'h000e;
	localparam logic [15:0] VLAN_HDR_BYTES = 16'h0012;
	localparam logic [15:0] FCS_BYTES = 16'h0004;
	localparam logic [15:0] PAD_LIMIT = 16'h0080;
	localparam logic [15:0] MAX_FRAME = 16'h05ee;
	localparam logic [15:0] MAX_VLAN_FRAME = 16'h05f2;
	localparam logic [15:0] CTL_FRAME_LEN = 16'h0040;
	localparam logic [15:0] LEN_TYPE_MAX = 16'h05dc;
	localparam logic [15:0] TYPE_VLAN = 16'h8100;
	localparam logic [15:0] TYPE_MAC_CTL = 16'h8808;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic long_frame;
		logic strip_crc;
		logic strip_pad;
		logic speed10;
		logic loopback;
		logic full_duplex;
		logic tx_en;
	} mfss_ctrl_t;
	localparam mfss_ctrl_t CTRL_RST = 7'h00;
	typedef struct packed {
		logic [4:0] attempts;
		logic xdefer;
		logic defer;
		logic nohb;
		logic late_col;
		logic exc_col;
		logic lost_crs;
		logic underrun;
		logic done;
	} mfss_txstat_t;
	typedef struct packed {
		logic [15:0] length;
		logic truncated;
		logic ctl_len_err;
		logic len_err;
		logic mii_err;
		logic overflow;
		logic crc_err;
		logic dangling;
		logic done;
	} mfss_rxstat_t;
	typedef struct packed {
		logic [7:0] data;
		logic eof;
		logic odd_nibble;
		logic rx_er;
		logic overflow;
	} mfss_rxbyte_t;
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} mfss_qbyte_t;
endpackage : mfss_pkg

/* rtl/mfss_crc32.sv */
`timescale 1ns/1ps
module mfss_crc32 (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic en_i,
	input wire logic [7:0] data_i,
	output logic ok_o
);
	typedef struct packed {
		logic [31:0] crc;
		logic ok;
	} mfss_crc_st_t;
	mfss_crc_st_t st;
	mfss_crc_st_t next_st;

	always_comb begin
		logic [31:0] c;
		c = st.crc ^ {24'h000000, data_i};
		next_st = st;
		if (clear_i) begin
			next_st.crc = mfss_pkg::CRC_INIT;
		end else if (en_i) begin
			for (int i = 0; i < 8; i++) begin
				c = c[0] ? ((c >> 1) ^ mfss_pkg::CRC_POLY) : (c >> 1);
			end
			next_st.crc = c;
		end
		// Running over data and FCS leaves a fixed residue when the frame is intact.
		next_st.ok = (next_st.crc == mfss_pkg::CRC_RESIDUE);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= {mfss_pkg::CRC_INIT, 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign ok_o = st.ok;
endmodule : mfss_crc32

/* rtl/mfss_frame_status.sv */
// What this block does
// - Pad strip only frames under 128 bytes.
// - Stripped padding also removes that frame's FCS.
// - CRC always checked, even when stripped.
// - CRC strip removes FCS from every frame.
// - Classifier drop flags error; unqueued frame discarded.
// - Late classifier drop truncates, discards remaining bytes.
// - At most one status entry per frame each direction.
// - Transmit FIFO 80 bytes, first 64 retained.
// - Underrun aborts, flags, discards rest of frame.
// - Half duplex lost carrier flagged, no abort.
// - No lost carrier in loopback or full duplex.
// - Sixteen collisions abort with excessive-collision flag.
// - Collision after 64 bytes: late flag, abort.
// - 10 Mbps: no heartbeat in 40 bits flagged.
// - Deferral without collision sets deferral flag.
// - Excessive deferral flagged; aborts if transmit disabled.
// - Odd nibble with bad CRC sets dangling, CRC.
// - Failed CRC check sets CRC-error flag.
// - Receive FIFO overflow flagged, rest dropped; unqueued frame discarded.
// - Over-length frame with a length field flagged unless long-frame mode.
// - MAC control frame not 64 bytes flagged.
// - PHY receive error sets media-error flag.
// - No free status entry: whole frame dropped.
`timescale 1ns/1ps
module mfss_frame_status #(
	parameter int XDEF_CYC_10 = mfss_pkg::XDEF_CYC_10,
	parameter int XDEF_CYC_100 = mfss_pkg::XDEF_CYC_100,
	parameter int BLOCK_BYTES = mfss_pkg::BLOCK_BYTES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic txq_valid_i,
	input wire mfss_pkg::mfss_qbyte_t txq_byte_i,
	output logic txq_ready_o,
	input wire logic tx_pop_i,
	output mfss_pkg::mfss_qbyte_t tx_byte_o,
	output logic tx_avail_o,
	input wire logic tx_defer_i,
	input wire logic tx_sfd_i,
	input wire logic tx_end_i,
	input wire logic col_i,
	input wire logic crs_i,
	output logic tx_retry_o,
	output logic tx_abort_o,
	output logic txs_valid_o,
	output mfss_pkg::mfss_txstat_t txs_data_o,
	input wire logic rxf_valid_i,
	input wire mfss_pkg::mfss_rxbyte_t rxf_byte_i,
	input wire logic rxs_full_i,
	input wire logic cls_drop_i,
	output logic rxq_valid_o,
	output mfss_pkg::mfss_qbyte_t rxq_byte_o,
	output logic rxq_drop_o,
	output logic [15:0] rxq_keep_o,
	output logic rxs_valid_o,
	output mfss_pkg::mfss_rxstat_t rxs_data_o
);
	localparam int NB = mfss_pkg::TX_FIFO_BYTES;

	typedef struct packed {
		mfss_pkg::mfss_ctrl_t ctrl;
		logic ack;
		logic [31:0] rdat;
		logic [2:0] col_sync;
		logic [2:0] crs_sync;
		logic col;
		logic crs;
		logic [NB-1:0][8:0] mem;
		logic [6:0] base;
		logic [6:0] held;
		logic [6:0] sent;
		logic committed;
		logic last_in;
		logic discard;
		logic txq_ready;
		mfss_pkg::mfss_qbyte_t tx_byte;
		logic tx_avail;
		logic in_tx;
		logic col_seen;
		logic defer_seen;
		logic hb_wait;
		logic hb_seen;
		logic [7:0] hb_cnt;
		logic [6:0] xbytes;
		logic [16:0] dcnt;
		mfss_pkg::mfss_txstat_t txs;
		mfss_pkg::mfss_txstat_t txs_out;
		logic txs_valid;
		logic tx_retry;
		logic tx_abort;
		logic [15:0] pos;
		logic [15:0] lt1;
		logic [15:0] lt2;
		logic rx_skip;
		logic rx_stop;
		logic rx_fin;
		mfss_pkg::mfss_rxstat_t rxs;
		mfss_pkg::mfss_rxstat_t rxs_out;
		logic rxs_valid;
		mfss_pkg::mfss_qbyte_t rxq_byte;
		logic rxq_valid;
		logic rxq_drop;
		logic [15:0] rxq_keep;
	} mfss_st_t;

	mfss_st_t st;
	mfss_st_t next_st;
	logic crc_ok;

	function automatic logic [6:0] wrap(input logic [7:0] a);
		wrap = (a >= 8'(NB)) ? 7'(a - 8'(NB)) : a[6:0];
	endfunction : wrap

	// ----------------------------------------------------------------
	// Frame check, run over every received byte including the FCS
	// ----------------------------------------------------------------
	mfss_crc32 u_crc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(st.rx_fin),
		.en_i(rxf_valid_i),
		.data_i(rxf_byte_i.data),
		.ok_o(crc_ok)
	);

	always_comb begin
		logic half;
		logic col_rise;
		logic abort;
		logic fin;
		logic skip_now;
		logic stop_now;
		logic vlan;
		logic is_len;
		logic [15:0] lf;
		logic [15:0] hdr;
		logic [15:0] tot;
		logic [16:0] dlim;
		logic [6:0] rd_idx;
		logic [6:0] wr_idx;
		half = !st.ctrl.full_duplex;
		abort = 1'b0;
		fin = 1'b0;
		skip_now = 1'b0;
		stop_now = 1'b0;
		vlan = 1'b0;
		is_len = 1'b0;
		lf = 16'h0000;
		hdr = 16'h0000;
		tot = st.pos + 16'h0001;
		dlim = st.ctrl.speed10 ? 17'(XDEF_CYC_10) : 17'(XDEF_CYC_100);
		rd_idx = wrap({1'b0, st.base} + {1'b0, st.sent});
		wr_idx = wrap({1'b0, st.base} + {1'b0, st.held});
		col_rise = 1'b0;
		next_st = st;
		next_st.tx_retry = 1'b0;
		next_st.tx_abort = 1'b0;
		next_st.txs_valid = 1'b0;
		next_st.rxq_valid = 1'b0;
		next_st.rxq_drop = 1'b0;
		next_st.rxs_valid = 1'b0;

		// ------------------------------------------------------------
		// Register bus
		// ------------------------------------------------------------
		next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
		if (wb_cyc_i && wb_stb_i && !st.ack) begin
			case (wb_adr_i)
				mfss_pkg::ADR_CTRL: next_st.rdat = {25'h0000000, st.ctrl};
				mfss_pkg::ADR_TXS: next_st.rdat = {19'h00000, st.txs_out};
				mfss_pkg::ADR_RXS: next_st.rdat = {8'h00, st.rxs_out};
				mfss_pkg::ADR_FILL: next_st.rdat = {17'h00000, st.sent, 1'b0, st.held};
				default: next_st.rdat = 32'h00000000;
			endcase
		end
		if (wb_cyc_i && wb_stb_i && st.ack && wb_we_i && wb_sel_i[0]
				&& wb_adr_i == mfss_pkg::ADR_CTRL) begin
			next_st.ctrl = mfss_pkg::mfss_ctrl_t'(wb_dat_i[6:0]);
		end

		// ------------------------------------------------------------
		// Pin synchronisers
		// ------------------------------------------------------------
		next_st.col_sync = {st.col_sync[1:0], col_i};
		next_st.crs_sync = {st.crs_sync[1:0], crs_i};
		if (st.col_sync[1] == st.col_sync[2]) begin
			next_st.col = st.col_sync[2];
			col_rise = half && st.col_sync[2] && !st.col;
		end
		if (st.crs_sync[1] == st.crs_sync[2]) begin
			next_st.crs = st.crs_sync[2];
		end

		// ------------------------------------------------------------
		// Transmit FIFO; holds a single frame so a flush never hits the next one
		// ------------------------------------------------------------
		if (txq_valid_i && st.txq_ready) begin
			if (st.discard) begin
				next_st.discard = !txq_byte_i.last;
			end else begin
				next_st.mem[wr_idx] = txq_byte_i;
				next_st.held = st.held + 7'h01;
				next_st.last_in = txq_byte_i.last;
			end
		end
		if (tx_pop_i) begin
			if (!st.tx_avail) begin
				next_st.txs.underrun = 1'b1;
				abort = 1'b1;
			end else begin
				next_st.tx_byte = st.mem[rd_idx];
				if (st.xbytes != 7'h7f) begin
					next_st.xbytes = st.xbytes + 7'h01;
				end
				if (st.committed) begin
					next_st.base = wrap({1'b0, st.base} + 8'h01);
					next_st.held = next_st.held - 7'h01;
				end else if (st.sent + 7'h01 == mfss_pkg::TX_KEEP_BYTES) begin
					// Once the window is passed the frame can no longer be retried, so free the retained bytes.
					next_st.base = wrap({1'b0, st.base} + {1'b0, mfss_pkg::TX_KEEP_BYTES});
					next_st.held = next_st.held - mfss_pkg::TX_KEEP_BYTES;
					next_st.sent = 7'h00;
					next_st.committed = 1'b1;
				end else begin
					next_st.sent = st.sent + 7'h01;
				end
			end
		end

		// ------------------------------------------------------------
		// Transmit status
		// ------------------------------------------------------------
		if (tx_defer_i && half && st.held != 7'h00) begin
			next_st.defer_seen = 1'b1;
			if (st.dcnt != dlim) begin
				next_st.dcnt = st.dcnt + 17'h00001;
			end
			if (st.dcnt + 17'h00001 == dlim) begin
				next_st.txs.xdefer = 1'b1;
				abort = abort || !st.ctrl.tx_en;
			end
		end else begin
			next_st.dcnt = 17'h00000;
		end
		if (tx_sfd_i) begin
			next_st.in_tx = 1'b1;
			next_st.xbytes = 7'h00;
		end
		if (st.in_tx && half && !st.ctrl.loopback && !st.crs) begin
			next_st.txs.lost_crs = 1'b1;
		end
		if (st.in_tx && col_rise) begin
			next_st.col_seen = 1'b1;
			next_st.in_tx = 1'b0;
			next_st.txs.attempts = st.txs.attempts + 5'h01;
			if (st.xbytes >= mfss_pkg::LATE_WIN_BYTES) begin
				next_st.txs.late_col = 1'b1;
				abort = 1'b1;
			end else if (st.txs.attempts + 5'h01 == mfss_pkg::MAX_ATTEMPTS) begin
				next_st.txs.exc_col = 1'b1;
				abort = 1'b1;
			end else begin
				next_st.tx_retry = 1'b1;
				next_st.sent = 7'h00;
			end
		end
		if (tx_end_i && st.in_tx) begin
			next_st.in_tx = 1'b0;
			if (st.ctrl.speed10) begin
				next_st.hb_wait = 1'b1;
				next_st.hb_seen = 1'b0;
				next_st.hb_cnt = 8'(mfss_pkg::HB_CYC);
			end else begin
				fin = 1'b1;
			end
		end
		if (st.hb_wait) begin
			next_st.hb_seen = st.hb_seen || st.col;
			if (st.hb_cnt == 8'h01) begin
				next_st.hb_wait = 1'b0;
				next_st.txs.nohb = !(st.hb_seen || st.col);
				fin = 1'b1;
			end else begin
				next_st.hb_cnt = st.hb_cnt - 8'h01;
			end
		end
		if (abort) begin
			next_st.tx_abort = 1'b1;
			next_st.in_tx = 1'b0;
			next_st.hb_wait = 1'b0;
			next_st.discard = !next_st.last_in;
			fin = 1'b1;
		end
		if (fin) begin
			next_st.txs_valid = 1'b1;
			next_st.txs_out = next_st.txs;
			next_st.txs_out.done = 1'b1;
			next_st.txs_out.defer = st.defer_seen && !next_st.col_seen;
			next_st.txs = '0;
			next_st.col_seen = 1'b0;
			next_st.defer_seen = 1'b0;
			next_st.base = wrap({1'b0, next_st.base} + {1'b0, next_st.held});
			next_st.held = 7'h00;
			next_st.sent = 7'h00;
			next_st.committed = 1'b0;
			next_st.last_in = 1'b0;
		end
		next_st.tx_avail = next_st.sent < next_st.held;
		next_st.txq_ready = next_st.discard
			|| (!next_st.last_in && next_st.held < 7'(NB));

		// ------------------------------------------------------------
		// Receive path: the cycle after end of frame carries the CRC verdict
		// ------------------------------------------------------------
		if (st.rx_fin) begin
			next_st.rx_fin = 1'b0;
			// A frame dropped before any block was queued leaves no entry behind.
			if (!st.rx_skip) begin
				next_st.rxs_valid = 1'b1;
				next_st.rxs_out = st.rxs;
				next_st.rxs_out.done = 1'b1;
				next_st.rxs_out.crc_err = !crc_ok;
				next_st.rxs_out.dangling = st.rxs.dangling && !crc_ok;
			end
			next_st.rxs = '0;
			next_st.pos = 16'h0000;
			next_st.rx_skip = 1'b0;
			next_st.rx_stop = 1'b0;
		end
		if (rxf_valid_i) begin
			skip_now = st.rx_skip || (st.pos == 16'h0000 && rxs_full_i);
			if (st.pos == 16'h0000 && rxs_full_i) begin
				next_st.rx_skip = 1'b1;
				next_st.rxq_drop = 1'b1;
			end
			if (st.pos != 16'hffff) begin
				next_st.pos = tot;
			end
			unique case (st.pos)
				mfss_pkg::POS_LT_HI: next_st.lt1[15:8] = rxf_byte_i.data;
				mfss_pkg::POS_LT_LO: next_st.lt1[7:0] = rxf_byte_i.data;
				mfss_pkg::POS_VLT_HI: next_st.lt2[15:8] = rxf_byte_i.data;
				mfss_pkg::POS_VLT_LO: next_st.lt2[7:0] = rxf_byte_i.data;
				default: next_st.lt1 = next_st.lt1;
			endcase
			if (rxf_byte_i.rx_er) begin
				next_st.rxs.mii_err = 1'b1;
			end
			if (rxf_byte_i.overflow) begin
				next_st.rxs.overflow = 1'b1;
			end
		end
		if ((rxf_valid_i || st.pos != 16'h0000) && !st.rx_fin && !skip_now && !st.rx_stop
				&& (cls_drop_i || (rxf_valid_i && rxf_byte_i.overflow))) begin
			next_st.rx_stop = 1'b1;
			next_st.rx_skip = st.pos < 16'(BLOCK_BYTES);
			next_st.rxq_drop = 1'b1;
			next_st.rxs.truncated = 1'b1;
			stop_now = 1'b1;
		end
		if (rxf_valid_i) begin
			if (!skip_now && !stop_now && !st.rx_stop) begin
				next_st.rxq_valid = 1'b1;
				next_st.rxq_byte = {rxf_byte_i.data, rxf_byte_i.eof};
			end
			if (rxf_byte_i.eof) begin
				vlan = next_st.lt1 == mfss_pkg::TYPE_VLAN;
				lf = vlan ? next_st.lt2 : next_st.lt1;
				hdr = vlan ? mfss_pkg::VLAN_HDR_BYTES : mfss_pkg::HDR_BYTES;
				is_len = lf <= mfss_pkg::LEN_TYPE_MAX;
				next_st.rx_fin = 1'b1;
				next_st.rxs.length = tot;
				next_st.rxs.dangling = rxf_byte_i.odd_nibble;
				next_st.rxs.len_err = is_len && !st.ctrl.long_frame
					&& tot > (vlan ? mfss_pkg::MAX_VLAN_FRAME : mfss_pkg::MAX_FRAME);
				next_st.rxs.ctl_len_err = next_st.lt1 == mfss_pkg::TYPE_MAC_CTL
					&& tot != mfss_pkg::CTL_FRAME_LEN;
				if (st.ctrl.strip_pad && is_len && tot < mfss_pkg::PAD_LIMIT
						&& hdr + lf + mfss_pkg::FCS_BYTES < tot) begin
					next_st.rxq_keep = hdr + lf;
				end else if (st.ctrl.strip_crc) begin
					next_st.rxq_keep = tot - mfss_pkg::FCS_BYTES;
				end else begin
					next_st.rxq_keep = tot;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
			st.ctrl <= mfss_pkg::CTRL_RST;
		end else begin
			st <= next_st;
		end
	end

	assign wb_dat_o = st.rdat;
	assign wb_ack_o = st.ack;
	assign txq_ready_o = st.txq_ready;
	assign tx_byte_o = st.tx_byte;
	assign tx_avail_o = st.tx_avail;
	assign tx_retry_o = st.tx_retry;
	assign tx_abort_o = st.tx_abort;
	assign txs_valid_o = st.txs_valid;
	assign txs_data_o = st.txs_out;
	assign rxq_valid_o = st.rxq_valid;
	assign rxq_byte_o = st.rxq_byte;
	assign rxq_drop_o = st.rxq_drop;
	assign rxq_keep_o = st.rxq_keep;
	assign rxs_valid_o = st.rxs_valid;
	assign rxs_data_o = st.rxs_out;
endmodule : mfss_frame_status

/* sim/mfss_frame_status_chk.sv */
`timescale 1ns/1ps
// --------------------
// Port checker
// --------------------
module mfss_frame_status_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic tx_pop_i,
	input wire logic tx_avail_o,
	input wire logic tx_retry_o,
	input wire logic tx_abort_o,
	input wire logic txs_valid_o,
	input wire mfss_pkg::mfss_txstat_t txs_data_o,
	input wire logic rxq_valid_o,
	input wire mfss_pkg::mfss_qbyte_t rxq_byte_o,
	input wire logic rxq_drop_o,
	input wire logic rxs_valid_o,
	input wire mfss_pkg::mfss_rxstat_t rxs_data_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	chk_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single pulse after request");
	chk_underrun_abort: assert property (tx_pop_i && !tx_avail_o |-> ##[1:3] tx_abort_o)
		else $error("underrun did not abort");
	chk_retry_alone: assert property (tx_retry_o |-> !tx_abort_o && !txs_valid_o)
		else $error("retry together with abort or status");
	chk_excess_count: assert property (txs_valid_o && txs_data_o.exc_col |->
		txs_data_o.attempts == mfss_pkg::MAX_ATTEMPTS)
		else $error("excessive collision at wrong attempt count");
	chk_tx_entry: assert property (txs_valid_o |-> txs_data_o.done ##1 !txs_valid_o)
		else $error("tx status entry malformed");
	chk_align_crc: assert property (rxs_valid_o && rxs_data_o.dangling |-> rxs_data_o.crc_err)
		else $error("dangling byte without crc error");
	chk_drop_quiet: assert property (rxq_drop_o |=> !rxq_valid_o [*2])
		else $error("bytes after drop");
	chk_rx_entry: assert property (rxq_valid_o && rxq_byte_o.last |=> rxs_valid_o && rxs_data_o.done)
		else $error("no rx status after last byte");
	chk_rx_single: assert property (rxs_valid_o |=> !rxs_valid_o [*2])
		else $error("rx status repeated");
endmodule : mfss_frame_status_chk

bind mfss_frame_status mfss_frame_status_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.tx_pop_i, .tx_avail_o, .tx_retry_o, .tx_abort_o, .txs_valid_o, .txs_data_o, .rxq_valid_o,
	.rxq_byte_o, .rxq_drop_o, .rxs_valid_o, .rxs_data_o);

/* sim/mfss_rxq_model.sv */
`timescale 1ns/1ps
// --------------------
// Receive FIFO side model
// --------------------
module mfss_rxq_model (
	input wire logic clk_i,
	output logic rxf_valid_o,
	output mfss_pkg::mfss_rxbyte_t rxf_byte_o
);
	logic [7:0] mem [0:1599];
	initial begin
		rxf_valid_o = 1'b0;
		rxf_byte_o = '0;
	end
	// The reader never pops on two consecutive clocks, so each byte is followed by a gap.
	task automatic send(input int n, input int err_at, input int ovf_at, input logic odd);
		for (int i = 0; i < n; i++) begin
			rxf_valid_o <= 1'b1;
			rxf_byte_o <= {mem[i], i == n - 1, odd && i == n - 1, i == err_at, i == ovf_at};
			@(posedge clk_i);
			rxf_valid_o <= 1'b0;
			// Data is not held once the byte is taken, so a stale match cannot pass.
			rxf_byte_o <= {~mem[i], 4'h0};
			@(posedge clk_i);
		end
	endtask : send
endmodule : mfss_rxq_model

/* sim/mfss_frame_status_tb_top.sv */
`timescale 1ns/1ps
// --------------------
// Bench
// --------------------
module mfss_frame_status_tb_top;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, txq_valid_i, txq_ready_o;
	logic tx_pop_i, tx_avail_o, tx_defer_i, tx_sfd_i, tx_end_i, col_i, crs_i, tx_retry_o;
	logic tx_abort_o, txs_valid_o, rxf_valid_i, rxs_full_i, cls_drop_i, rxq_valid_o;
	logic rxq_drop_o, rxs_valid_o;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [15:0] rxq_keep_o, keep;
	mfss_pkg::mfss_qbyte_t txq_byte_i, rxq_byte_o, tx_byte_o;
	mfss_pkg::mfss_txstat_t txs_data_o, txs;
	mfss_pkg::mfss_rxstat_t rxs_data_o, rxs;
	mfss_pkg::mfss_rxbyte_t rxf_byte_i;
	int err_total, checked, n_txs, n_rxs, n_drop, n_abort, b, d, b_tx, b_ab;
	int tc[7] = '{0, 16, 16, 16, 32, 48, 16};
	int tn[7] = '{64, 64, 127, 128, 128, 64, 64};
	int tk[7] = '{64, 24, 24, 128, 124, 24, 24};

	mfss_frame_status #(.XDEF_CYC_10(20), .XDEF_CYC_100(10)) u_dut (.clk_i, .rst_i, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.txq_valid_i, .txq_byte_i, .txq_ready_o, .tx_pop_i, .tx_byte_o, .tx_avail_o, .tx_defer_i,
		.tx_sfd_i, .tx_end_i, .col_i, .crs_i, .tx_retry_o, .tx_abort_o, .txs_valid_o, .txs_data_o,
		.rxf_valid_i, .rxf_byte_i, .rxs_full_i, .cls_drop_i, .rxq_valid_o, .rxq_byte_o,
		.rxq_drop_o, .rxq_keep_o, .rxs_valid_o, .rxs_data_o);
	mfss_rxq_model u_rxm (.clk_i, .rxf_valid_o(rxf_valid_i), .rxf_byte_o(rxf_byte_i));

	always @(posedge clk_i) begin
		if (txs_valid_o === 1'b1) begin
			txs <= txs_data_o;
			n_txs <= n_txs + 1;
		end
		if (rxs_valid_o === 1'b1) begin
			rxs <= rxs_data_o;
			n_rxs <= n_rxs + 1;
		end
		if (rxq_valid_o === 1'b1 && rxq_byte_o.last === 1'b1)
			keep <= rxq_keep_o;
		n_drop <= n_drop + int'(rxq_drop_o === 1'b1);
		n_abort <= n_abort + int'(tx_abort_o === 1'b1);
	end

	task automatic chk(input logic ok, input string what);
		checked++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask : chk

	task automatic print_verdict;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	task automatic mark;
		b = n_rxs;
		d = n_drop;
		b_tx = n_txs;
		b_ab = n_abort;
	endtask : mark

	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] v);
		c = c ^ {24'h0, v};
		for (int k = 0; k < 8; k++)
			c = c[0] ? (c >> 1) ^ mfss_pkg::CRC_POLY : c >> 1;
		return c;
	endfunction : crc_step

	task automatic rx(input int n, input logic [15:0] lt, input logic bad, input int er,
		input int ov, input logic odd);
		logic [31:0] c;
		c = mfss_pkg::CRC_INIT;
		for (int i = 0; i < n - 4; i++) begin
			u_rxm.mem[i] = (i == 12) ? lt[15:8] : (i == 13) ? lt[7:0] : 8'(i * 7);
			c = crc_step(c, u_rxm.mem[i]);
		end
		// The check sequence goes out inverted, low byte first.
		for (int j = 0; j < 4; j++)
			u_rxm.mem[n - 4 + j] = ~c[8 * j +: 8] ^ {7'h0, bad && j == 3};
		u_rxm.send(n, er, ov, odd);
		repeat (6) @(posedge clk_i);
	endtask : rx

	task automatic drop_at(input int k);
		repeat (k) @(posedge clk_i);
		cls_drop_i <= 1'b1;
		@(posedge clk_i);
		cls_drop_i <= 1'b0;
	endtask : drop_at

	task automatic tx(input int np, input int npop, input int ncol, input int dfr, input logic hb);
		int a0;
		a0 = n_abort;
		for (int i = 0; i < np; i++) begin
			txq_valid_i <= 1'b1;
			txq_byte_i <= {8'(i), i == np - 1};
			do @(posedge clk_i); while (txq_ready_o !== 1'b1);
		end
		txq_valid_i <= 1'b0;
		if (dfr > 0) begin
			tx_defer_i <= 1'b1;
			repeat (dfr) @(posedge clk_i);
			tx_defer_i <= 1'b0;
		end
		for (int a = 0; a <= ncol && n_abort == a0; a++) begin
			tx_sfd_i <= 1'b1;
			@(posedge clk_i);
			tx_sfd_i <= 1'b0;
			for (int i = 0; i < npop && n_abort == a0; i++) begin
				tx_pop_i <= 1'b1;
				@(posedge clk_i);
			end
			tx_pop_i <= 1'b0;
			if (a < ncol) begin
				// Four cycles, so the pin synchroniser passes it.
				col_i <= 1'b1;
				repeat (4) @(posedge clk_i);
				col_i <= 1'b0;
				repeat (6) @(posedge clk_i);
			end else if (n_abort == a0) begin
				tx_end_i <= 1'b1;
				@(posedge clk_i);
				tx_end_i <= 1'b0;
				repeat (20) @(posedge clk_i);
				col_i <= hb;
				repeat (4) @(posedge clk_i);
				col_i <= 1'b0;
			end
		end
		for (int t = 0; t < 300 && n_txs == b_tx; t++)
			@(posedge clk_i);
		repeat (4) @(posedge clk_i);
	endtask : tx

	task automatic tcase(input logic [6:0] c, input logic cr, input int np, input int npop,
		input int ncol, input int dfr, input logic hb, input logic [7:0] f, input int ab);
		wb(1'b1, mfss_pkg::ADR_CTRL, {25'h0, c});
		crs_i <= cr;
		repeat (8) @(posedge clk_i);
		mark();
		tx(np, npop, ncol, dfr, hb);
		chk(n_txs == b_tx + 1 && txs[7:0] === f && n_abort == b_ab + ab, "tx status");
	endtask : tcase

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	initial begin
		repeat (100000) @(posedge clk_i);
		chk(1'b0, "watchdog expired");
		print_verdict();
	end

	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, txq_valid_i, tx_pop_i, tx_defer_i} = 7'h40;
		{tx_sfd_i, tx_end_i, col_i, crs_i, rxs_full_i, cls_drop_i} = 6'h00;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		txq_byte_i = '0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, mfss_pkg::ADR_CTRL, 32'h0);
		chk(rd === 32'h0, "ctrl reset value");
		wb(1'b1, mfss_pkg::ADR_CTRL, 32'hffffffff);
		wb(1'b0, mfss_pkg::ADR_CTRL, 32'h0);
		chk(rd === 32'h7f, "ctrl readback");
		wb(1'b1, 8'h10, 32'hffffffff);
		wb(1'b0, 8'h10, 32'h0);
		chk(rd === 32'h0, "unmapped read");
		for (int i = 0; i < 7; i++) begin
			wb(1'b1, mfss_pkg::ADR_CTRL, 32'(tc[i]));
			mark();
			rx(tn[i], i == 0 ? 16'h0800 : 16'h000a, i == 6, -1, -1, 1'b0);
			chk(keep === 16'(tk[i]), "kept length");
			chk(n_rxs == b + 1 && rxs.crc_err === (i == 6), "crc verdict");
		end
		wb(1'b1, mfss_pkg::ADR_CTRL, 32'h0);
		rx(64, 16'h0800, 1'b1, -1, -1, 1'b1);
		chk(rxs[2:1] === 2'b11, "alignment");
		rx(64, 16'h0800, 1'b0, -1, -1, 1'b1);
		chk(rxs[2:1] === 2'b00, "odd nibble good crc");
		rx(64, 16'h0800, 1'b0, 20, -1, 1'b0);
		chk(rxs.mii_err === 1'b1, "media error");
		rx(1519, 16'h05dc, 1'b0, -1, -1, 1'b0);
		chk(rxs.len_err === 1'b1, "over length");
		rx(60, 16'h8808, 1'b0, -1, -1, 1'b0);
		chk(rxs.ctl_len_err === 1'b1, "short control frame");
		rx(64, 16'h8808, 1'b0, -1, -1, 1'b0);
		chk(rxs[7:1] === 7'h00, "flags cleared");
		wb(1'b1, mfss_pkg::ADR_CTRL, 32'h40);
		rx(1519, 16'h05dc, 1'b0, -1, -1, 1'b0);
		chk(rxs.len_err === 1'b0, "long frame mode");
		mark();
		rx(100, 16'h0800, 1'b0, -1, 70, 1'b0);
		chk(n_drop == d + 1 && n_rxs == b + 1 && rxs.overflow === 1'b1, "overflow");
		mark();
		fork
			rx(64, 16'h0800, 1'b0, -1, -1, 1'b0);
			drop_at(20);
		join
		chk(n_drop == d + 1 && n_rxs == b, "early drop");
		mark();
		fork
			rx(100, 16'h0800, 1'b0, -1, -1, 1'b0);
			drop_at(150);
		join
		chk(n_drop == d + 1 && n_rxs == b + 1 && rxs.truncated === 1'b1, "late drop");
		mark();
		rxs_full_i <= 1'b1;
		rx(64, 16'h0800, 1'b0, -1, -1, 1'b0);
		rxs_full_i <= 1'b0;
		chk(n_drop == d + 1 && n_rxs == b, "no status room");
		tcase(7'h01, 1'b1, 20, 20, 0, 0, 1'b0, 8'h01, 0);
		tcase(7'h01, 1'b1, 20, 20, 0, 3, 1'b0, 8'h41, 0);
		tcase(7'h01, 1'b0, 20, 20, 0, 0, 1'b0, 8'h05, 0);
		tcase(7'h03, 1'b0, 20, 20, 0, 0, 1'b0, 8'h01, 0);
		tcase(7'h05, 1'b0, 20, 20, 0, 0, 1'b0, 8'h01, 0);
		tcase(7'h01, 1'b1, 10, 11, 0, 0, 1'b0, 8'h03, 1);
		tcase(7'h01, 1'b1, 70, 66, 1, 0, 1'b0, 8'h11, 1);
		chk(tx_byte_o === {8'h41, 1'b0}, "byte after window");
		tcase(7'h01, 1'b1, 10, 2, 16, 0, 1'b0, 8'h09, 1);
		tcase(7'h00, 1'b1, 10, 10, 0, 30, 1'b0, 8'hc1, 1);
		tcase(7'h09, 1'b1, 20, 20, 0, 0, 1'b0, 8'h21, 0);
		tcase(7'h09, 1'b1, 20, 20, 0, 0, 1'b1, 8'h01, 0);
		wb(1'b1, mfss_pkg::ADR_TXS, 32'h0);
		wb(1'b0, mfss_pkg::ADR_TXS, 32'h0);
		chk(rd === {19'h0, txs}, "tx status register");
		print_verdict();
	end
endmodule : mfss_frame_status_tb_top
